/* File: psr_pkg.sv */
// constants and types shared by the parameter save/restore block
package psr_pkg;

  // ******************************************************
  // register port and object addresses
  // ******************************************************
  localparam int          AW          = 24;
  localparam int          DW          = 32;
  localparam logic [15:0] OBJ_STORE   = 16'h1010;
  localparam logic [15:0] OBJ_RESTORE = 16'h1011;
  localparam logic [15:0] OBJ_MARKER  = 16'h1020;
  localparam logic [15:0] OBJ_REBOOT  = 16'h2800;
  localparam logic [15:0] OBJ_IRQ     = 16'h5F00;
  localparam logic [7:0]  SUB_ALL     = 8'h01;
  localparam logic [7:0]  SUB_FIRST   = 8'h02;
  localparam logic [7:0]  SUB_LAST    = 8'h06;
  localparam logic [7:0]  SUB_MARK2   = 8'h02;
  localparam logic [7:0]  SUB_STAT    = 8'h01;
  localparam logic [7:0]  SUB_MASK    = 8'h02;

  // ******************************************************
  // keys and entry values
  // ******************************************************
  localparam logic [31:0] KEY_SAVE   = 32'h65766173;
  localparam logic [31:0] KEY_LOAD   = 32'h64616F6C;
  localparam logic [31:0] KEY_BOOT   = 32'h746F6F62;
  localparam logic [31:0] ENTRY_DONE = 32'h00000001;
  localparam logic [31:0] ENTRY_RST  = 32'h00000001;
  localparam logic [31:0] MARK_RST   = 32'h00000000;

  // ******************************************************
  // categories: comm, application, user, movement, tuning
  // ******************************************************
  localparam int        NCAT         = 5;
  localparam logic [4:0] CATS_ALL     = 5'h1F;
  localparam logic [4:0] CATS_FACTORY = 5'h0F;
  localparam logic [4:0] CATS_NONE    = 5'h00;

  // ******************************************************
  // interrupt status bits
  // ******************************************************
  localparam int IW       = 3;
  localparam int IRQ_SAVE = 0;
  localparam int IRQ_DISC = 1;
  localparam int IRQ_MARK = 2;

  // ******************************************************
  // timing
  // ******************************************************
  localparam int CLK_HZ      = 25_000_000;
  localparam int SAVE_MS     = 2000;
  localparam int DISC_MS     = 100;
  localparam int SAVE_CYC    = (CLK_HZ / 1000) * SAVE_MS;
  localparam int DISC_CYC    = (CLK_HZ / 1000) * DISC_MS;
  localparam int RESTART_NS  = 1000;
  localparam int RESTART_CYC =
    (RESTART_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CW          = 27;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN  = 2'h1,
    ST_DONE = 2'h3
  } psr_state_t;

  // category mask of a store or restore entry
  function automatic logic [4:0] cat_of(input logic [7:0] sub,
                                        input logic       rst);
    logic [4:0] m;
    m = CATS_NONE;
    if (sub == SUB_ALL) begin
      m = rst ? CATS_FACTORY : CATS_ALL;
    end else if (sub >= SUB_FIRST && sub <= SUB_LAST) begin
      m = 5'h01 << 3'(sub - SUB_FIRST);
    end
    return m;
  endfunction

  // true for a category entry subindex 01..06
  function automatic logic is_entry(input logic [7:0] sub);
    return (sub >= SUB_ALL) && (sub <= SUB_LAST);
  endfunction

endpackage

/* File: psr_nv_store.sv */
// non-volatile image engine: timed commit and discard of categories
`timescale 1ns/1ps
module psr_nv_store import psr_pkg::*; #(
  parameter int SAVE_T = SAVE_CYC,
  parameter int DISC_T = DISC_CYC
) (
  input  wire logic          clk_in,
  input  wire logic          nrst_in,
  input  wire logic          start_in,
  input  wire logic          discard_in,
  input  wire logic [4:0]    cats_in,
  input  wire logic [DW-1:0] mark0_in,
  input  wire logic [DW-1:0] mark1_in,
  output logic               done_out,
  output logic [4:0]         saved_out,
  output logic [DW-1:0]      smark0_out,
  output logic [DW-1:0]      smark1_out
);
  logic [CW-1:0] cnt_q;
  logic          run_q;
  logic          disc_q;
  logic [4:0]    cats_q;
  logic [DW-1:0] m0_q;
  logic [DW-1:0] m1_q;

  // the commit is timed as a whole; a partial image never shows
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_q    <= 1'b0;
      disc_q   <= 1'b0;
      cats_q   <= CATS_NONE;
      cnt_q    <= '0;
      done_out <= 1'b0;
      m0_q     <= MARK_RST;
      m1_q     <= MARK_RST;
    end else begin
      done_out <= 1'b0;
      if (start_in && !run_q) begin
        run_q  <= 1'b1;
        disc_q <= discard_in;
        cats_q <= cats_in;
        m0_q   <= mark0_in;
        m1_q   <= mark1_in;
        cnt_q  <= discard_in ? CW'(DISC_T - 1) : CW'(SAVE_T - 1);
      end else if (run_q) begin
        if (cnt_q == '0) begin
          run_q    <= 1'b0;
          done_out <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      saved_out  <= CATS_NONE;
      smark0_out <= MARK_RST;
      smark1_out <= MARK_RST;
    end else if (run_q && cnt_q == '0) begin
      if (disc_q) begin
        saved_out <= saved_out & ~cats_q;
        if (cats_q == CATS_FACTORY) begin
          smark0_out <= MARK_RST;
          smark1_out <= MARK_RST;
        end
      end else begin
        saved_out <= saved_out | cats_q;
        if (cats_q == CATS_ALL) begin
          smark0_out <= m0_q;
          smark1_out <= m1_q;
        end
      end
    end
  end
endmodule

/* File: psr_restart.sv */
// controller restart sequencer: timed restart level, then a reload pulse
`timescale 1ns/1ps
module psr_restart import psr_pkg::*; (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic trig_in,
  output logic      restart_out,
  output logic      reload_out
);
  logic [7:0] cnt_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      restart_out <= 1'b0;
      reload_out  <= 1'b0;
      cnt_q       <= 8'h00;
    end else begin
      reload_out <= 1'b0;
      if (trig_in && !restart_out) begin
        restart_out <= 1'b1;
        cnt_q       <= 8'(RESTART_CYC - 1);
      end else if (restart_out) begin
        if (cnt_q == 8'h00) begin
          restart_out <= 1'b0;
          reload_out  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end
endmodule

/* File: psr_top.sv */
// parameter save/restore block: store, discard, marker and restart
`timescale 1ns/1ps
module psr_top import psr_pkg::*; #(
  parameter int SAVE_T = SAVE_CYC,
  parameter int DISC_T = DISC_CYC
) (
  input  wire logic          clk_in,
  input  wire logic          nrst_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [DW-1:0] wdata_in,
  input  wire logic          wr_in,
  input  wire logic          rd_in,
  input  wire logic          savable_wr_in,
  output logic [DW-1:0]      rdata_out,
  output logic               irq_out,
  output logic               busy_out,
  output logic               restart_out,
  output logic [4:0]         use_saved_out
);

  // ******************************************************
  // address decode
  // ******************************************************
  logic [15:0] a_obj;
  logic [7:0]  a_sub;
  logic        wr_store;
  logic        wr_rest;
  logic        wr_mark;
  logic        wr_boot;
  logic        wr_stat;
  logic        wr_mask;

  assign a_obj    = addr_in[23:8];
  assign a_sub    = addr_in[7:0];
  assign wr_store = wr_in && a_obj == OBJ_STORE && is_entry(a_sub);
  assign wr_rest  = wr_in && a_obj == OBJ_RESTORE && is_entry(a_sub);
  assign wr_mark  = wr_in && a_obj == OBJ_MARKER
                    && a_sub >= SUB_ALL && a_sub <= SUB_MARK2;
  assign wr_boot  = wr_in && a_obj == OBJ_REBOOT && a_sub == SUB_ALL;
  assign wr_stat  = wr_in && a_obj == OBJ_IRQ && a_sub == SUB_STAT;
  assign wr_mask  = wr_in && a_obj == OBJ_IRQ && a_sub == SUB_MASK;

  // ******************************************************
  // request acceptance
  // ******************************************************
  psr_state_t state_q;
  logic       idle;
  logic       go_save;
  logic       go_disc;
  logic       start;
  logic       nv_done;
  logic       reload;
  logic       boot_trig;

  assign idle    = state_q == ST_IDLE && !restart_out;
  // a non-key value is only stored, it launches nothing
  assign go_save = idle && wr_store && wdata_in == KEY_SAVE;
  assign go_disc = idle && wr_rest && wdata_in == KEY_LOAD;
  assign start   = go_save || go_disc;
  assign boot_trig = wr_boot && wdata_in == KEY_BOOT;

  // ******************************************************
  // operation sequencer
  // ******************************************************
  logic       op_disc_q;
  logic [7:0] op_sub_q;
  logic [4:0] op_cats_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (nv_done) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      op_disc_q <= 1'b0;
      op_sub_q  <= 8'h00;
      op_cats_q <= CATS_NONE;
    end else if (start) begin
      op_disc_q <= go_disc;
      op_sub_q  <= a_sub;
      op_cats_q <= cat_of(a_sub, go_disc);
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_out <= 1'b0;
    end else begin
      // stays high through the write-back of 1, so software
      // that sees busy low also sees the entry at 1
      busy_out <= start || state_q == ST_RUN;
    end
  end

  // ******************************************************
  // store and restore entries
  // ******************************************************
  logic [DW-1:0] store_q [1:6];
  logic [DW-1:0] rest_q  [1:6];

  generate
    for (genvar g = 1; g <= 6; g++) begin : g_ent
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          store_q[g] <= ENTRY_RST;
        end else if (state_q == ST_DONE && !op_disc_q
                     && op_sub_q == 8'(g)) begin
          store_q[g] <= ENTRY_DONE;
        end else if (idle && wr_store && a_sub == 8'(g)) begin
          store_q[g] <= wdata_in;
        end
      end

      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          rest_q[g] <= ENTRY_RST;
        end else if (state_q == ST_DONE && op_disc_q
                     && op_sub_q == 8'(g)) begin
          rest_q[g] <= ENTRY_DONE;
        end else if (idle && wr_rest && a_sub == 8'(g)) begin
          rest_q[g] <= wdata_in;
        end
      end
    end
  endgenerate

  // ******************************************************
  // non-volatile image and restart
  // ******************************************************
  logic [4:0]    saved;
  logic [DW-1:0] smark0;
  logic [DW-1:0] smark1;
  logic [DW-1:0] mark_q [1:2];

  psr_nv_store #(
    .SAVE_T (SAVE_T),
    .DISC_T (DISC_T)
  ) u_nv (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .start_in   (start),
    .discard_in (go_disc),
    .cats_in    (cat_of(a_sub, go_disc)),
    .mark0_in   (mark_q[1]),
    .mark1_in   (mark_q[2]),
    .done_out   (nv_done),
    .saved_out  (saved),
    .smark0_out (smark0),
    .smark1_out (smark1)
  );

  psr_restart u_rst (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .trig_in     (boot_trig),
    .restart_out (restart_out),
    .reload_out  (reload)
  );

  // working set follows the image only at restart
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      use_saved_out <= CATS_NONE;
    end else if (reload) begin
      use_saved_out <= saved;
    end
  end

  logic [DW-1:0] boot_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      boot_q <= MARK_RST;
    end else if (wr_boot) begin
      boot_q <= wdata_in;
    end
  end

  // ******************************************************
  // configuration marker
  // ******************************************************
  logic mark_clr;

  // store 01 and the marker itself are exempt from clearing
  assign mark_clr = savable_wr_in || wr_boot
                    || (wr_store && a_sub != SUB_ALL);

  generate
    for (genvar m = 1; m <= 2; m++) begin : g_mark
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          mark_q[m] <= MARK_RST;
        end else if (reload) begin
          mark_q[m] <= (m == 1) ? smark0 : smark1;
        end else if (mark_clr) begin
          mark_q[m] <= MARK_RST;
        end else if (wr_mark && a_sub == 8'(m)) begin
          mark_q[m] <= wdata_in;
        end
      end
    end
  endgenerate

  // ******************************************************
  // interrupts
  // ******************************************************
  logic [IW-1:0] stat_q;
  logic [IW-1:0] mask_q;
  logic [IW-1:0] ev;
  logic          mark_nz;

  assign mark_nz = mark_q[1] != MARK_RST || mark_q[2] != MARK_RST;
  assign ev[IRQ_SAVE] = state_q == ST_DONE && !op_disc_q;
  assign ev[IRQ_DISC] = state_q == ST_DONE && op_disc_q;
  assign ev[IRQ_MARK] = mark_clr && mark_nz && !reload;

  // an event in the clearing cycle stays set
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? wdata_in[IW-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= wdata_in[IW-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((stat_q & ~(wr_stat ? wdata_in[IW-1:0] : '0))
                   | ev) & (wr_mask ? wdata_in[IW-1:0] : mask_q));
    end
  end

  // ******************************************************
  // read port
  // ******************************************************
  logic [DW-1:0] rd_d;

  always_comb begin
    rd_d = '0;
    if (a_obj == OBJ_STORE && is_entry(a_sub)) begin
      rd_d = store_q[3'(a_sub)];
    end else if (a_obj == OBJ_RESTORE && is_entry(a_sub)) begin
      rd_d = rest_q[3'(a_sub)];
    end else if (a_obj == OBJ_MARKER && a_sub == SUB_ALL) begin
      rd_d = mark_q[1];
    end else if (a_obj == OBJ_MARKER && a_sub == SUB_MARK2) begin
      rd_d = mark_q[2];
    end else if (a_obj == OBJ_REBOOT && a_sub == SUB_ALL) begin
      rd_d = boot_q;
    end else if (a_obj == OBJ_IRQ && a_sub == SUB_STAT) begin
      rd_d = {{(DW-IW){1'b0}}, stat_q};
    end else if (a_obj == OBJ_IRQ && a_sub == SUB_MASK) begin
      rd_d = {{(DW-IW){1'b0}}, mask_q};
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      rdata_out <= rd_d;
    end else begin
      rdata_out <= '0;
    end
  end

endmodule

/* File: psr_top_asserts.sv */
// port-level assertions for the parameter save/restore block
`timescale 1ns/1ps
module psr_top_chk import psr_pkg::*; #(
  parameter int SAVE_T = SAVE_CYC,
  parameter int DISC_T = DISC_CYC
) (
  input  wire logic          clk_in,
  input  wire logic          nrst_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [DW-1:0] wdata_in,
  input  wire logic          wr_in,
  input  wire logic          rd_in,
  input  wire logic          savable_wr_in,
  input  wire logic [DW-1:0] rdata_out,
  input  wire logic          irq_out,
  input  wire logic          busy_out,
  input  wire logic          restart_out,
  input  wire logic [4:0]    use_saved_out
);
  // ****************************
  // decode and run-length counters
  // ****************************
  logic        idle;
  logic        st_wr;
  logic        rs_wr;
  logic        bt_wr;
  logic [31:0] busy_q;
  logic [7:0]  rst_q;
  assign idle  = !busy_out && !restart_out;
  assign st_wr = wr_in && addr_in[23:8] == OBJ_STORE
                 && is_entry(addr_in[7:0]);
  assign rs_wr = wr_in && addr_in[23:8] == OBJ_RESTORE
                 && is_entry(addr_in[7:0]);
  assign bt_wr = wr_in && addr_in == {OBJ_REBOOT, 8'h01}
                 && wdata_in == KEY_BOOT;
  // counters hold the run length at the edge where the level falls
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_q <= 32'h0;
    end else begin
      busy_q <= busy_out ? busy_q + 32'h1 : 32'h0;
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_q <= 8'h0;
    end else begin
      rst_q <= restart_out ? rst_q + 8'h1 : 8'h0;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  // ****************************
  // properties
  // ****************************
  property p_save_go;
    st_wr && wdata_in == KEY_SAVE && idle |=> busy_out;
  endproperty
  a_save_go: assert property (p_save_go)
    else $error("save key did not start a save");
  property p_load_go;
    rs_wr && wdata_in == KEY_LOAD && idle |=> busy_out;
  endproperty
  a_load_go: assert property (p_load_go)
    else $error("load key did not start a discard");
  property p_no_key;
    ((st_wr && wdata_in != KEY_SAVE) || (rs_wr && wdata_in != KEY_LOAD))
      && idle |=> !busy_out;
  endproperty
  a_no_key: assert property (p_no_key)
    else $error("non-key value started an operation");
  property p_busy_cap;
    busy_q <= SAVE_T + 4;
  endproperty
  a_busy_cap: assert property (p_busy_cap)
    else $error("operation never finished");
  property p_busy_min;
    $fell(busy_out) |-> busy_q >= DISC_T;
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("operation finished too early");
  property p_boot;
    bt_wr && !restart_out |=> restart_out;
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot key did not restart");
  property p_rs_len;
    $fell(restart_out) |-> rst_q == RESTART_CYC;
  endproperty
  a_rs_len: assert property (p_rs_len)
    else $error("restart level has wrong length");
  property p_use_hold;
    !$past(restart_out) && !$past(restart_out, 2)
      && !$past(restart_out, 3) |-> $stable(use_saved_out);
  endproperty
  a_use_hold: assert property (p_use_hold)
    else $error("loaded categories changed without restart");
  property p_mark_clr;
    rd_in && addr_in[23:8] == OBJ_MARKER && $past(savable_wr_in)
      && !restart_out && !$past(restart_out) && !$past(restart_out, 2)
      |=> rdata_out == MARK_RST;
  endproperty
  a_mark_clr: assert property (p_mark_clr)
    else $error("marker not cleared by savable write");
  c_save: cover property (st_wr && wdata_in == KEY_SAVE && idle);
  c_load: cover property (rs_wr && wdata_in == KEY_LOAD && idle);
  c_boot: cover property ($fell(restart_out));
  c_mark: cover property (savable_wr_in ##1 rd_in);
endmodule
bind psr_top psr_top_chk #(.SAVE_T(SAVE_T), .DISC_T(DISC_T)) u_chk (
  .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .savable_wr_in(savable_wr_in), .rdata_out(rdata_out),
  .irq_out(irq_out), .busy_out(busy_out), .restart_out(restart_out),
  .use_saved_out(use_saved_out));

/* File: psr_host_model.sv */
// configuration tool model driving the register port
`timescale 1ns/1ps
module psr_host_model import psr_pkg::*; (
  input  wire logic [DW-1:0] rdata_in,
  input  wire logic          clk_in,
  output logic [AW-1:0]      addr_out,
  output logic [DW-1:0]      wdata_out,
  output logic               wr_out,
  output logic               rd_out
);
  initial begin
    addr_out = 24'h0;
    wdata_out = 32'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // released lines are inverted so stale values never look valid
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    d = rdata_in;
  endtask
  // nothing else is issued until the entry reads 1 or 100 reads have gone by
  task automatic wait_one(input logic [AW-1:0] a,
                          output logic [DW-1:0] d);
    int n;
    n = 0;
    d = 32'h0;
    while (d !== ENTRY_DONE && n < 100) begin
      rd(a, d);
      n++;
    end
  endtask
endmodule

/* File: tb_top.sv */
// self-checking testbench for the parameter save/restore block
`timescale 1ns/1ps
module tb_top import psr_pkg::*;;
  localparam int ST = 12;
  localparam int DT = 8;
  logic          clk_in = 1'b0;
  logic          nrst_in = 1'b0;
  logic          savable_wr_in = 1'b0;
  logic [AW-1:0] addr_in;
  logic [DW-1:0] wdata_in;
  logic [DW-1:0] rdata_out;
  logic          wr_in;
  logic          rd_in;
  logic          irq_out;
  logic          busy_out;
  logic          restart_out;
  logic [4:0]    use_saved_out;
  int            failures = 0;
  int            compares = 0;
  always #20 clk_in = ~clk_in;
  psr_host_model u_host (.rdata_in(rdata_out), .clk_in(clk_in),
    .addr_out(addr_in), .wdata_out(wdata_in), .wr_out(wr_in),
    .rd_out(rd_in));
  psr_top #(.SAVE_T(ST), .DISC_T(DT)) DUT (.clk_in(clk_in),
    .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .savable_wr_in(savable_wr_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .busy_out(busy_out),
    .restart_out(restart_out), .use_saved_out(use_saved_out));
  // ****************************
  // checking and closing
  // ****************************
  task automatic chk(input string n, input logic [DW-1:0] e, g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic rdchk(input string n, input logic [AW-1:0] a,
                       input logic [DW-1:0] e);
    logic [DW-1:0] v;
    u_host.rd(a, v);
    chk(n, e, v);
  endtask
  task automatic pulse_sav();
    @(posedge clk_in);
    savable_wr_in <= 1'b1;
    fork
      begin
        @(posedge clk_in);
        savable_wr_in <= 1'b0;
      end
    join_none
  endtask
  task automatic op(input logic [15:0] obj, input logic [7:0] sub,
                    input logic [DW-1:0] key);
    logic [DW-1:0] v;
    u_host.wr({obj, sub}, key);
    @(posedge clk_in);
    chk("busy_rise", 32'h1, 32'(busy_out));
    u_host.wait_one({obj, sub}, v);
    chk("entry_done", ENTRY_DONE, v);
    chk("busy_fall", 32'h0, 32'(busy_out));
  endtask
  task automatic reboot();
    int n;
    n = 0;
    u_host.wr({OBJ_REBOOT, 8'h01}, KEY_BOOT);
    @(posedge clk_in);
    while (restart_out === 1'b1 && n < 100) begin
      n++;
      @(posedge clk_in);
    end
    chk("restart_len", 32'(RESTART_CYC), 32'(n));
    repeat (3) @(posedge clk_in);
  endtask
  // ****************************
  // scenarios
  // ****************************
  task automatic t_reset();
    for (int s = 1; s <= 6; s++) begin
      rdchk("store_rst", {OBJ_STORE, 8'(s)}, ENTRY_RST);
      rdchk("restore_rst", {OBJ_RESTORE, 8'(s)}, ENTRY_RST);
    end
    rdchk("marker_rst", {OBJ_MARKER, 8'h01}, MARK_RST);
    rdchk("reboot_rst", {OBJ_REBOOT, 8'h01}, 32'h0);
    rdchk("stat_rst", {OBJ_IRQ, SUB_STAT}, 32'h0);
    u_host.wr(24'h4A0001, 32'h0000005A);
    rdchk("unmapped", 24'h4A0001, 32'h0);
    chk("use_rst", 32'h0, 32'(use_saved_out));
  endtask
  task automatic t_nonkey();
    u_host.wr({OBJ_STORE, 8'h03}, 32'h00000002);
    u_host.wr({OBJ_RESTORE, 8'h03}, KEY_SAVE);
    @(posedge clk_in);
    chk("nonkey_busy", 32'h0, 32'(busy_out));
    rdchk("nonkey_entry", {OBJ_STORE, 8'h03}, 32'h00000002);
  endtask
  task automatic t_save_all();
    u_host.wr({OBJ_IRQ, SUB_MASK}, 32'h00000003);
    u_host.wr({OBJ_MARKER, 8'h01}, 32'h0000A5C3);
    u_host.wr({OBJ_MARKER, SUB_MARK2}, 32'h00001234);
    op(OBJ_STORE, SUB_ALL, KEY_SAVE);
    rdchk("mark_kept", {OBJ_MARKER, 8'h01}, 32'h0000A5C3);
    chk("irq_save", 32'h1, 32'(irq_out));
    rdchk("stat_save", {OBJ_IRQ, SUB_STAT}, 32'h1);
    u_host.wr({OBJ_IRQ, SUB_STAT}, 32'h1);
    repeat (2) @(posedge clk_in);
    chk("irq_clr", 32'h0, 32'(irq_out));
    u_host.wr({OBJ_MARKER, 8'h01}, 32'h00000077);
    reboot();
    chk("use_all", 32'(CATS_ALL), 32'(use_saved_out));
    rdchk("mark1", {OBJ_MARKER, 8'h01}, 32'h0000A5C3);
    rdchk("mark2", {OBJ_MARKER, SUB_MARK2}, 32'h00001234);
  endtask
  task automatic t_discard();
    op(OBJ_RESTORE, SUB_ALL, KEY_LOAD);
    chk("use_hold", 32'(CATS_ALL), 32'(use_saved_out));
    chk("irq_disc", 32'h1, 32'(irq_out));
    u_host.wr({OBJ_IRQ, SUB_STAT}, 32'h7);
    reboot();
    chk("use_factory", 32'h10, 32'(use_saved_out));
    op(OBJ_RESTORE, 8'h06, KEY_LOAD);
    reboot();
    chk("use_none", 32'h0, 32'(use_saved_out));
  endtask
  task automatic t_each();
    logic [4:0] m;
    m = 5'h00;
    for (int s = 2; s <= 6; s++) begin
      op(OBJ_STORE, 8'(s), KEY_SAVE);
      m[s-2] = 1'b1;
      reboot();
      chk("use_cat", 32'(m), 32'(use_saved_out));
    end
  endtask
  task automatic t_marker();
    u_host.wr({OBJ_IRQ, SUB_STAT}, 32'h7);
    u_host.wr({OBJ_IRQ, SUB_MASK}, 32'h4);
    u_host.wr({OBJ_MARKER, 8'h01}, 32'h00000055);
    pulse_sav();
    rdchk("mark_clr", {OBJ_MARKER, 8'h01}, MARK_RST);
    chk("irq_mark", 32'h1, 32'(irq_out));
    u_host.wr({OBJ_IRQ, SUB_STAT}, 32'h4);
    repeat (2) @(posedge clk_in);
    chk("irq_mark_clr", 32'h0, 32'(irq_out));
    u_host.wr({OBJ_MARKER, SUB_MARK2}, 32'h00000007);
    u_host.wr({OBJ_STORE, 8'h02}, 32'h00000003);
    rdchk("mark_store", {OBJ_MARKER, SUB_MARK2}, MARK_RST);
    u_host.wr({OBJ_MARKER, 8'h01}, 32'h00000009);
    u_host.wr({OBJ_STORE, SUB_ALL}, 32'h00000003);
    rdchk("mark_exempt", {OBJ_MARKER, 8'h01}, 32'h00000009);
  endtask
  task automatic t_refuse();
    logic [DW-1:0] v;
    u_host.wr({OBJ_STORE, 8'h05}, KEY_SAVE);
    u_host.wr({OBJ_RESTORE, 8'h05}, KEY_LOAD);
    u_host.wait_one({OBJ_STORE, 8'h05}, v);
    repeat (2) @(posedge clk_in);
    chk("refused_busy", 32'h0, 32'(busy_out));
    rdchk("refused_entry", {OBJ_RESTORE, 8'h05}, ENTRY_RST);
  endtask
  task automatic t_rst2();
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk("use_rst2", 32'h0, 32'(use_saved_out));
    nrst_in <= 1'b1;
    rdchk("store_rst2", {OBJ_STORE, 8'h06}, ENTRY_RST);
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_nonkey();
    t_save_all();
    t_discard();
    t_each();
    t_marker();
    t_refuse();
    t_rst2();
    conclude();
  end
  // a hang costs one mismatch and ends the run
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    conclude();
  end
endmodule
